//--- pio_params.svh
// Register map, field widths and reset values of the port register set
// ---------------------------------------------------------------------
// ---------------------------------------------------------------------
`ifndef PIO_PARAMS_SVH
`define PIO_PARAMS_SVH

`define PIO_NPORTS        6
`define PIO_NCELL_PORTS   3
`define PIO_PORT_C        3'h2
`define PIO_ADDR_W        8
// Port stride and register offsets inside one port's window
`define PIO_PORT_STRIDE   8'h20
`define PIO_OFS_DIN       3'h0
`define PIO_OFS_DOUT      3'h1
`define PIO_OFS_DIR       3'h2
`define PIO_OFS_DRV       3'h3
`define PIO_OFS_OEN       3'h4
`define PIO_OFS_CELL      3'h5
`define PIO_RST_DOUT      8'h00
`define PIO_RST_DIR       8'h00
`define PIO_RST_DRV       8'h00
`define PIO_RESP_OKAY     2'h0
`define PIO_RESP_SLVERR   2'h2

`endif

//--- pio_pkg.sv
// Types shared by the port register set
package pio_pkg;
  typedef struct packed {
    logic [7:0] dout;
    logic [7:0] dir;
    logic [7:0] drv;
  } pio_port_cfg_t;

  typedef struct packed {
    logic [7:0] o;
    logic [7:0] oe;
    logic [7:0] slew;
  } pio_pin_drive_t;

  typedef enum logic [1:0] {
    PIO_W_IDLE = 2'b00,
    PIO_W_RESP = 2'b01
  } pio_wr_state_t;
endpackage

//--- pio_port_regs.sv
// Configuration storage of one port with its pin driver logic
`timescale 1ns/1ps
`include "pio_params.svh"
module pio_port_regs
  import pio_pkg::*;
#(
  parameter bit IS_SLEW_PORT = 1'b0
) (
  // Clock and reset
  input  wire logic           ref_clk_i,
  input  wire logic           rst_n_i,
  // Register write
  input  wire logic           wr_i,
  input  wire logic [2:0]     wr_ofs_i,
  input  wire logic [7:0]     wr_data_i,
  // State out
  output pio_port_cfg_t       cfg_o,
  output pio_pin_drive_t      pin_o
);
  pio_port_cfg_t  cfg_q;
  pio_pin_drive_t pin_d;

  // ---------------------------------------------------------------
  // Writable registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      cfg_q.dout <= `PIO_RST_DOUT;
      cfg_q.dir  <= `PIO_RST_DIR;
      cfg_q.drv  <= `PIO_RST_DRV;
    end else if (wr_i) begin
      // Offsets of read-only registers fall through untouched
      case (wr_ofs_i)
        `PIO_OFS_DOUT: cfg_q.dout <= wr_data_i;
        `PIO_OFS_DIR:  cfg_q.dir  <= wr_data_i;
        `PIO_OFS_DRV:  cfg_q.drv  <= wr_data_i;
        default: begin
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Pin driver
  // ---------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin_d.o[i] = cfg_q.dout[i];
      if (IS_SLEW_PORT) begin
        pin_d.oe[i]   = cfg_q.dir[i];
        pin_d.slew[i] = cfg_q.drv[i];
      end else begin
        // Open drain only ever pulls low
        pin_d.oe[i]   = cfg_q.dir[i] &
                        (~cfg_q.drv[i] | ~cfg_q.dout[i]);
        pin_d.slew[i] = 1'b0;
      end
    end
  end

  assign cfg_o = cfg_q;
  assign pin_o = pin_d;
endmodule

//--- pio_top.sv
// Port register set top with AXI4-Lite slave and pin registers
`timescale 1ns/1ps
`include "pio_params.svh"
module pio_top
  import pio_pkg::*;
#(
  parameter int NPORTS = `PIO_NPORTS
) (
  // Clock and reset
  input  wire logic                     ref_clk_i,
  input  wire logic                     rst_n_i,
  // AXI4-Lite write address and data
  input  wire logic [`PIO_ADDR_W-1:0]   s_axi_awaddr_i,
  input  wire logic                     s_axi_awvalid_i,
  output logic                          s_axi_awready_o,
  input  wire logic [31:0]              s_axi_wdata_i,
  input  wire logic [3:0]               s_axi_wstrb_i,
  input  wire logic                     s_axi_wvalid_i,
  output logic                          s_axi_wready_o,
  // AXI4-Lite write response
  output logic [1:0]                    s_axi_bresp_o,
  output logic                          s_axi_bvalid_o,
  input  wire logic                     s_axi_bready_i,
  // AXI4-Lite read
  input  wire logic [`PIO_ADDR_W-1:0]   s_axi_araddr_i,
  input  wire logic                     s_axi_arvalid_i,
  output logic                          s_axi_arready_o,
  output logic [31:0]                   s_axi_rdata_o,
  output logic [1:0]                    s_axi_rresp_o,
  output logic                          s_axi_rvalid_o,
  input  wire logic                     s_axi_rready_i,
  // Port pins, index 0..5 = A,B,C,D,E,G
  input  wire logic [NPORTS-1:0][7:0]   pin_i,
  output logic [NPORTS-1:0][7:0]        pin_o,
  output logic [NPORTS-1:0][7:0]        pin_oe_o,
  output logic [7:0]                    pin_c_slew_o,
  // Input cell states of ports A,B,C
  input  wire logic [`PIO_NCELL_PORTS-1:0][7:0] input_cell_bits_i
);
  // The decode and the per-port drivers are laid out for six ports only
  if (NPORTS != `PIO_NPORTS) begin : g_nports_check
    $error("NPORTS must be 6");
  end

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  function automatic logic [2:0] port_of(input logic [7:0] a);
    port_of = a[7:5];
  endfunction

  function automatic logic [2:0] ofs_of(input logic [7:0] a);
    ofs_of = a[4:2];
  endfunction

  function automatic logic addr_ok(input logic [7:0] a);
    logic [2:0] p;
    logic [2:0] o;
    p = a[7:5];
    o = a[4:2];
    addr_ok = (a[1:0] == 2'h0) && (p < 3'(NPORTS)) &&
              (o <= `PIO_OFS_CELL) &&
              !(o >= `PIO_OFS_OEN && p > `PIO_PORT_C);
  endfunction

  // ---------------------------------------------------------------
  // Write channel
  // ---------------------------------------------------------------
  pio_wr_state_t         wst_q;
  logic                  aw_have_q;
  logic                  w_have_q;
  logic [7:0]            awaddr_q;
  logic [7:0]            wdata_q;
  logic                  wstrb0_q;
  logic                  wr_go;
  logic [NPORTS-1:0]     port_wr;

  assign wr_go = (wst_q == PIO_W_IDLE) && aw_have_q && w_have_q;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      wst_q      <= PIO_W_IDLE;
      aw_have_q  <= 1'b0;
      w_have_q   <= 1'b0;
      awaddr_q   <= 8'h00;
      wdata_q    <= 8'h00;
      wstrb0_q   <= 1'b0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= `PIO_RESP_OKAY;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_have_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_have_q <= 1'b1;
        wdata_q  <= s_axi_wdata_i[7:0];
        wstrb0_q <= s_axi_wstrb_i[0];
      end
      case (wst_q)
        PIO_W_IDLE: begin
          if (wr_go) begin
            aw_have_q      <= 1'b0;
            w_have_q       <= 1'b0;
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o  <= addr_ok(awaddr_q) ? `PIO_RESP_OKAY
                                                : `PIO_RESP_SLVERR;
            wst_q          <= PIO_W_RESP;
          end
        end
        PIO_W_RESP: begin
          if (s_axi_bready_i) begin
            s_axi_bvalid_o <= 1'b0;
            wst_q          <= PIO_W_IDLE;
          end
        end
        default: wst_q <= PIO_W_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o  <= 1'b0;
    end else begin
      s_axi_awready_o <= !aw_have_q && !(s_axi_awvalid_i &&
                         s_axi_awready_o) && (wst_q == PIO_W_IDLE);
      s_axi_wready_o  <= !w_have_q && !(s_axi_wvalid_i &&
                         s_axi_wready_o) && (wst_q == PIO_W_IDLE);
    end
  end

  // ---------------------------------------------------------------
  // Per-port storage
  // ---------------------------------------------------------------
  pio_port_cfg_t  [NPORTS-1:0] cfg;
  pio_pin_drive_t [NPORTS-1:0] drv;

  for (genvar p = 0; p < NPORTS; p++) begin : g_port
    // Byte lane 0 carries the register; other lanes are ignored
    assign port_wr[p] = wr_go && addr_ok(awaddr_q) && wstrb0_q &&
                        (port_of(awaddr_q) == 3'(p));
    pio_port_regs #(
      .IS_SLEW_PORT (p == 2)
    ) u_regs (
      .ref_clk_i (ref_clk_i),
      .rst_n_i   (rst_n_i),
      .wr_i      (port_wr[p]),
      .wr_ofs_i  (ofs_of(awaddr_q)),
      .wr_data_i (wdata_q),
      .cfg_o     (cfg[p]),
      .pin_o     (drv[p])
    );
  end

  // ---------------------------------------------------------------
  // Pin outputs
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      pin_o        <= '0;
      pin_oe_o     <= '0;
      pin_c_slew_o <= 8'h00;
    end else begin
      for (int p = 0; p < NPORTS; p++) begin
        pin_o[p]    <= drv[p].o;
        pin_oe_o[p] <= drv[p].oe;
      end
      pin_c_slew_o <= drv[2].slew;
    end
  end

  // ---------------------------------------------------------------
  // Read channel
  // ---------------------------------------------------------------
  function automatic logic [7:0] rd_mux(input logic [7:0] a);
    logic [2:0] p;
    p = port_of(a);
    rd_mux = 8'h00;
    if (addr_ok(a)) begin
      case (ofs_of(a))
        `PIO_OFS_DIN:  rd_mux = pin_i[p];
        `PIO_OFS_DOUT: rd_mux = cfg[p].dout;
        `PIO_OFS_DIR:  rd_mux = cfg[p].dir;
        `PIO_OFS_DRV:  rd_mux = cfg[p].drv;
        `PIO_OFS_OEN:  rd_mux = pin_oe_o[p];
        `PIO_OFS_CELL: rd_mux = input_cell_bits_i[p[1:0]];
        default:       rd_mux = 8'h00;
      endcase
    end
  endfunction

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= 32'h0000_0000;
      s_axi_rresp_o   <= `PIO_RESP_OKAY;
    end else begin
      s_axi_arready_o <= !s_axi_rvalid_o && !s_axi_arready_o;
      if (s_axi_arvalid_i && s_axi_arready_o) begin
        s_axi_arready_o <= 1'b0;
        s_axi_rvalid_o  <= 1'b1;
        s_axi_rdata_o   <= {24'h00_0000, rd_mux(s_axi_araddr_i)};
        s_axi_rresp_o   <= addr_ok(s_axi_araddr_i) ? `PIO_RESP_OKAY
                                                   : `PIO_RESP_SLVERR;
      end else if (s_axi_rvalid_o && s_axi_rready_i) begin
        s_axi_rvalid_o <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  property p_dir_reset;
    @(posedge ref_clk_i) $rose(rst_n_i) |-> pin_oe_o == '0;
  endproperty
  a_dir_reset: assert property (p_dir_reset)
    else $error("oe after reset");

  property p_out_follows;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      port_wr[3] && ofs_of(awaddr_q) == `PIO_OFS_DOUT |->
      ##2 pin_o[3] == $past(wdata_q, 2);
  endproperty
  a_out_follows: assert property (p_out_follows)
    else $error("latch");

  property p_od_never_high;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      ##1 (cfg[0].drv[0] && cfg[0].dout[0]) |=> !pin_oe_o[0][0];
  endproperty
  a_od_never_high: assert property (p_od_never_high)
    else $error("od");

  property p_c_slew;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      1'b1 |=> pin_c_slew_o == $past(cfg[2].drv);
  endproperty
  a_c_slew: assert property (p_c_slew) else $error("slew");

  property p_oe_matches_dir;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      1'b1 |=> pin_oe_o[2] == $past(cfg[2].dir);
  endproperty
  a_oe_matches_dir: assert property (p_oe_matches_dir)
    else $error("oe c");

  property p_ro_write;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      wr_go && ofs_of(awaddr_q) == `PIO_OFS_DIN |=> $stable(cfg);
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("ro write");

  property p_din_read;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i == 8'h00 |=>
      s_axi_rdata_o[7:0] == $past(pin_i[0]);
  endproperty
  a_din_read: assert property (p_din_read) else $error("din");

  property p_cell_read;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i == 8'h34 |=>
      s_axi_rdata_o[7:0] == $past(input_cell_bits_i[1]);
  endproperty
  a_cell_read: assert property (p_cell_read) else $error("cell");

  property p_oen_read;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i == 8'h10 |=>
      s_axi_rdata_o[7:0] == $past(pin_oe_o[0]);
  endproperty
  a_oen_read: assert property (p_oen_read) else $error("oen");

  property p_bresp_bound;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      wr_go |=> s_axi_bvalid_o;
  endproperty
  a_bresp_bound: assert property (p_bresp_bound)
    else $error("bvalid");

  c_write: cover property (@(posedge ref_clk_i) wr_go);
  c_read: cover property (@(posedge ref_clk_i)
    s_axi_rvalid_o && s_axi_rready_i);
  c_od: cover property (@(posedge ref_clk_i) cfg[0].drv[0] && cfg[0].dir[0]);
  c_slew: cover property (@(posedge ref_clk_i) pin_c_slew_o != 8'h00);
endmodule

//--- pio_pin_model.sv
// Pin wire model: device driver, external driver and pull-up
`timescale 1ns/1ps
module pio_pin_model #(
  parameter int NPORTS = 6
) (
  // Device side
  input  wire logic [NPORTS-1:0][7:0] dev_o_i,
  input  wire logic [NPORTS-1:0][7:0] dev_oe_i,
  // External circuitry
  input  wire logic [NPORTS-1:0][7:0] ext_d_i,
  input  wire logic [NPORTS-1:0][7:0] ext_en_i,
  // Level seen at the pins
  output logic      [NPORTS-1:0][7:0] pin_lvl_o
);
  // A released pin with no external driver floats up to the pull-up
  always_comb begin
    for (int p = 0; p < NPORTS; p++) begin
      for (int b = 0; b < 8; b++) begin
        pin_lvl_o[p][b] = dev_oe_i[p][b] ? dev_o_i[p][b] :
                          (ext_en_i[p][b] ? ext_d_i[p][b] : 1'b1);
      end
    end
  end
endmodule

//--- tb.sv
// Self-checking bench for the port register set
`timescale 1ns/1ps
`include "pio_params.svh"
module tb;
  logic             ref_clk_i;
  logic             rst_n_i;
  logic [7:0]       awaddr, araddr, slew;
  logic [31:0]      wdata, rdata;
  logic [3:0]       wstrb, wsel;
  logic             awvalid, wvalid, bready, arvalid, rready;
  logic             awready, wready, bvalid, arready, rvalid;
  logic [1:0]       bresp, rresp;
  logic [5:0][7:0]  pin_lvl, pin_out, pin_oe, ext_d, ext_en, ex;
  logic [2:0][7:0]  cells;
  int               fail_count, n_tests;
  localparam logic [1:0] OK  = `PIO_RESP_OKAY;
  localparam logic [1:0] ERR = `PIO_RESP_SLVERR;

  pio_top dut (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .pin_i(pin_lvl), .pin_o(pin_out),
    .pin_oe_o(pin_oe), .pin_c_slew_o(slew), .input_cell_bits_i(cells)
  );

  pio_pin_model pins (
    .dev_o_i(pin_out), .dev_oe_i(pin_oe), .ext_d_i(ext_d),
    .ext_en_i(ext_en), .pin_lvl_o(pin_lvl)
  );

  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end

  function automatic logic [7:0] adr(input int p, input int o);
    return 8'(p * 32 + o * 4);
  endfunction

  task automatic finish_test;
    if (fail_count == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [47:0] e,
                     input logic [47:0] g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic [1:0] er);
    int n;
    bit ta, td;
    n = 0;
    ta = 1'b0;
    td = 1'b0;
    @(posedge ref_clk_i);
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= wsel;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      n++;
      if (awvalid && awready === 1'b1) begin
        ta = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready === 1'b1) begin
        td = 1'b1;
        wvalid <= 1'b0;
      end
    end while (!(ta && td) && n < 50);
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (bvalid !== 1'b1 && n < 50);
    bready <= 1'b0;
    chk("wr_wait", 0, n >= 50);
    chk("bresp", er, bresp);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e,
                    input logic [1:0] er);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (arready !== 1'b1 && n < 50);
    arvalid <= 1'b0;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (rvalid !== 1'b1 && n < 50);
    rready <= 1'b0;
    chk("rd_wait", 0, n >= 50);
    chk("rdata", {24'h0, e}, rdata);
    chk("rresp", er, rresp);
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    for (int p = 0; p < 6; p++) begin
      rd(adr(p, 2), 8'h00, OK);
      rd(adr(p, 3), 8'h00, OK);
    end
    for (int p = 0; p < 3; p++) rd(adr(p, 4), 8'h00, OK);
    chk("pin_oe", 0, pin_oe);
  endtask

  task automatic t_out;
    for (int p = 0; p < 6; p++) begin
      ex[p] = 8'ha5 ^ 8'(p);
      wr(adr(p, 1), ex[p], OK);
      wr(adr(p, 2), 8'hff, OK);
    end
    @(posedge ref_clk_i);
    chk("pin_out", ex, pin_out);
    chk("pin_oe", {6{8'hff}}, pin_oe);
    for (int p = 0; p < 6; p++) begin
      rd(adr(p, 1), ex[p], OK);
      rd(adr(p, 0), ex[p], OK);
    end
  endtask

  task automatic t_din;
    ext_d[3] <= 8'h3c;
    ext_en[3] <= 8'hff;
    wr(adr(3, 2), 8'h00, OK);
    wr(adr(5, 2), 8'h0f, OK);
    @(posedge ref_clk_i);
    chk("oe_d", 8'h00, pin_oe[3]);
    chk("oe_g", 8'h0f, pin_oe[5]);
    rd(adr(3, 0), 8'h3c, OK);
    rd(adr(5, 0), 8'hf0 | (8'ha5 ^ 8'h05) & 8'h0f, OK);
  endtask

  task automatic t_od;
    wr(adr(0, 1), 8'h0f, OK);
    wr(adr(0, 3), 8'hff, OK);
    wr(adr(4, 3), 8'hff, OK);
    @(posedge ref_clk_i);
    chk("oe_a", 8'hf0, pin_oe[0]);
    chk("oe_e", 8'h5e, pin_oe[4]);
    rd(adr(0, 4), 8'hf0, OK);
    rd(adr(1, 4), 8'hff, OK);
    rd(adr(0, 0), 8'h0f, OK);
  endtask

  task automatic t_slew;
    wr(adr(2, 3), 8'haa, OK);
    @(posedge ref_clk_i);
    chk("slew", 8'haa, slew);
    chk("oe_c", 8'hff, pin_oe[2]);
    chk("out_c", 8'ha5 ^ 8'h02, pin_out[2]);
    rd(adr(2, 4), 8'hff, OK);
  endtask

  task automatic t_ro;
    cells <= {8'h5a, 8'h96, 8'h3c};
    for (int p = 0; p < 3; p++) begin
      wr(adr(1, (p == 0 ? 0 : p + 3)), 8'h00, OK);
    end
    wsel = 4'h0;
    wr(adr(1, 1), 8'h00, OK);
    wsel = 4'h1;
    for (int p = 0; p < 3; p++) rd(adr(p, 5), cells[p], OK);
    rd(adr(1, 4), 8'hff, OK);
    rd(adr(1, 1), 8'ha4, OK);
    chk("out_b", 8'ha4, pin_out[1]);
    chk("oe_b", 8'hff, pin_oe[1]);
  endtask

  task automatic t_bad;
    wr(8'hc4, 8'h00, ERR);
    rd(8'hc4, 8'h00, ERR);
    rd(8'h05, 8'h00, ERR);
    rd(8'h18, 8'h00, ERR);
    chk("pin_oe", {8'h0f, 8'h5e, 8'h00, 8'hff, 8'hff, 8'hf0}, pin_oe);
  endtask

  // Reset in mid-run must return configured ports to inputs
  task automatic t_rerst;
    rst_n_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    @(posedge ref_clk_i);
    chk("oe_rst", 0, pin_oe);
    chk("slew_rst", 0, slew);
    rd(adr(0, 2), 8'h00, OK);
    rd(adr(0, 3), 8'h00, OK);
    rd(adr(2, 3), 8'h00, OK);
    rd(adr(0, 4), 8'h00, OK);
  endtask

  initial begin
    rst_n_i = 1'b0;
    {awaddr, araddr, wdata, wstrb} = '0;
    wsel = 4'h1;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {ext_d, ext_en, cells, ex} = '0;
    fail_count = 0;
    n_tests = 0;
    repeat (20) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_out();
    t_din();
    t_od();
    t_slew();
    t_ro();
    t_bad();
    t_rerst();
    finish_test();
  end

  initial begin
    repeat (5000) @(posedge ref_clk_i);
    fail_count++;
    finish_test();
  end
endmodule
